// ===== hw/sfl_exec.sv
/*
 * Sequencer for frame building, stack pushes and counted loop prefixes.
 * Assumes the core hands one command at a time, runs the governed block
 * instruction on request and returns its zero and carry results.
 */
`timescale 1ns/10ps
`include "sfl_params.svh"

module sfl_exec
    import sfl_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          cmdValid,
    input  wire sfl_cmd_t      cmd,
    output logic               cmdReady,
    input  wire sfl_gpr_t      gpr,
    input  wire logic          regLoad,
    input  wire sfl_ptrs_t     regIn,
    output sfl_ptrs_t          regOut,
    output logic               memReq,
    output sfl_mem_req_t       memOp,
    input  wire logic          memAck,
    input  wire logic [15:0]   memRdata,
    output logic               execReq,
    input  wire logic          execDone,
    input  wire sfl_exec_res_t execFlags,
    output logic               pcAdvance,
    output logic               opDone,
    output logic               intInhibit
);

    function automatic logic [15:0] dec2(input logic [15:0] v);
        dec2 = 16'(v - `SFL_WORD_BYTES);
    endfunction

    function automatic logic [15:0] signExt8(input logic [7:0] v);
        signExt8 = {{8{v[7]}}, v};
    endfunction

    sfl_state_t   state_reg, state_next;
    logic [15:0]  sp_reg, sp_next, bp_reg, bp_next, cw_reg, cw_next;
    logic [15:0]  temp_reg, temp_next, wdata_reg, wdata_next, size_reg, size_next;
    logic [7:0]   cnt_reg, cnt_next;
    logic [2:0]   idx_reg, idx_next;
    sfl_op_t      mode_reg, mode_next;
    logic         pend_reg, pend_next;
    logic         ready_reg, exec_reg, exec_next, adv_reg, adv_next;
    logic         done_reg, done_next, inh_reg;

    wire logic        accDone;
    wire logic [15:0] accRdata;
    wire logic        accState = state_reg inside {SFL_ST_PUSH, SFL_ST_FSAVE,
        SFL_ST_FREAD, SFL_ST_FCOPY, SFL_ST_FTEMP, SFL_ST_PALL};
    wire logic        accStart = accState && !pend_reg;
    wire logic        isLoop   = cmd.op inside {SFL_OP_LOOP_PLAIN,
        SFL_OP_LOOP_WHILE_EQUAL, SFL_OP_LOOP_WHILE_CARRY};
    wire logic [15:0] cwDec    = 16'(cw_reg - `SFL_ONE16);
    wire logic [15:0] regsetWord;
    wire logic [15:0] accWdata;
    wire logic        loopExit;
    sfl_mem_req_t     accReq;

    ////////////////////////////////////////////////////////////////////////////////
    // Write data and address selection.
    assign regsetWord = (idx_reg == 3'h0) ? gpr.accumulatorWord :
                        (idx_reg == 3'h1) ? cw_reg :
                        (idx_reg == 3'h2) ? gpr.dataPortRegister :
                        (idx_reg == 3'h3) ? gpr.baseGeneralRegister :
                        (idx_reg == `SFL_REGSET_TEMP) ? temp_reg :
                        (idx_reg == 3'h5) ? bp_reg :
                        (idx_reg == 3'h6) ? gpr.sourcePointer : gpr.destPointer;
    assign accWdata = (state_reg == SFL_ST_FSAVE) ? bp_reg :
                      (state_reg == SFL_ST_FCOPY) ? accRdata :
                      (state_reg == SFL_ST_FTEMP) ? temp_reg :
                      (state_reg == SFL_ST_PALL)  ? regsetWord : wdata_reg;
    assign accReq.we    = (state_reg != SFL_ST_FREAD);
    assign accReq.addr  = (state_reg == SFL_ST_FREAD) ? dec2(bp_reg) : dec2(sp_reg);
    assign accReq.wdata = accWdata;

    // The exit decision reads only the flags returned with this pass, so a stale
    // flag from before the prefix can never end or extend the loop.
    assign loopExit = (cwDec == `SFL_ZERO16) ||
        (mode_reg == SFL_OP_LOOP_WHILE_EQUAL && !execFlags.zero) ||
        (mode_reg == SFL_OP_LOOP_WHILE_CARRY && !execFlags.carry);

    sfl_stack_port u_port (
        .mclk     (mclk),
        .rst      (rst),
        .start    (accStart),
        .reqIn    (accReq),
        .done     (accDone),
        .rdata    (accRdata),
        .memReq   (memReq),
        .memOp    (memOp),
        .memAck   (memAck),
        .memRdata (memRdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_comb begin
        state_next = state_reg;
        sp_next    = sp_reg;
        bp_next    = bp_reg;
        cw_next    = cw_reg;
        temp_next  = temp_reg;
        wdata_next = wdata_reg;
        size_next  = size_reg;
        cnt_next   = cnt_reg;
        idx_next   = idx_reg;
        mode_next  = mode_reg;
        exec_next  = 1'b0;
        adv_next   = 1'b0;
        done_next  = 1'b0;
        pend_next  = accStart ? 1'b1 : (accDone ? 1'b0 : pend_reg);
        unique case (state_reg)
            SFL_ST_IDLE: begin
                if (regLoad && !cmdValid) begin
                    sp_next = regIn.stackTop;
                    bp_next = regIn.frameBase;
                    cw_next = regIn.loopCounter;
                end
                if (cmdValid) begin
                    mode_next = cmd.op;
                    if (cmd.op == SFL_OP_PUSH_WORD) begin
                        wdata_next = cmd.operand;
                        state_next = SFL_ST_PUSH;
                    end else if (cmd.op == SFL_OP_PUSH_IMM8) begin
                        wdata_next = signExt8(cmd.imm8);
                        state_next = SFL_ST_PUSH;
                    end else if (cmd.op == SFL_OP_PUSH_REGSET) begin
                        temp_next  = sp_reg;
                        idx_next   = 3'h0;
                        state_next = SFL_ST_PALL;
                    end else if (cmd.op == SFL_OP_BUILD_FRAME) begin
                        size_next  = cmd.imm16;
                        cnt_next   = cmd.imm8;
                        state_next = SFL_ST_FSAVE;
                    end else if (isLoop && cw_reg == `SFL_ZERO16) begin
                        adv_next  = 1'b1;
                        done_next = 1'b1;
                    end else if (isLoop) begin
                        state_next = SFL_ST_LRUN;
                    end else begin
                        done_next = 1'b1;
                    end
                end
            end
            SFL_ST_PUSH: begin
                if (accDone) begin
                    sp_next    = dec2(sp_reg);
                    done_next  = 1'b1;
                    state_next = SFL_ST_IDLE;
                end
            end
            SFL_ST_FSAVE: begin
                if (accDone) begin
                    sp_next   = dec2(sp_reg);
                    temp_next = dec2(sp_reg);
                    cnt_next  = 8'(cnt_reg - `SFL_ONE8);
                    if (cnt_reg == `SFL_ZERO8) begin
                        state_next = SFL_ST_FDONE;
                    end else if (cnt_reg == `SFL_ONE8) begin
                        state_next = SFL_ST_FTEMP;
                    end else begin
                        state_next = SFL_ST_FREAD;
                    end
                end
            end
            SFL_ST_FREAD: begin
                if (accDone) begin
                    state_next = SFL_ST_FCOPY;
                end
            end
            SFL_ST_FCOPY: begin
                if (accDone) begin
                    sp_next    = dec2(sp_reg);
                    bp_next    = dec2(bp_reg);
                    cnt_next   = 8'(cnt_reg - `SFL_ONE8);
                    state_next = (cnt_reg == `SFL_ONE8) ? SFL_ST_FTEMP : SFL_ST_FREAD;
                end
            end
            SFL_ST_FTEMP: begin
                if (accDone) begin
                    sp_next    = dec2(sp_reg);
                    state_next = SFL_ST_FDONE;
                end
            end
            SFL_ST_FDONE: begin
                bp_next    = temp_reg;
                sp_next    = 16'(sp_reg - size_reg);
                done_next  = 1'b1;
                state_next = SFL_ST_IDLE;
            end
            SFL_ST_PALL: begin
                if (accDone) begin
                    sp_next  = dec2(sp_reg);
                    idx_next = 3'(idx_reg + 3'h1);
                    if (idx_reg == `SFL_REGSET_LAST) begin
                        done_next  = 1'b1;
                        state_next = SFL_ST_IDLE;
                    end
                end
            end
            SFL_ST_LRUN: begin
                exec_next  = 1'b1;
                state_next = SFL_ST_LWAIT;
            end
            SFL_ST_LWAIT: begin
                if (execDone) begin
                    cw_next = cwDec;
                    if (loopExit) begin
                        adv_next   = 1'b1;
                        done_next  = 1'b1;
                        state_next = SFL_ST_IDLE;
                    end else begin
                        state_next = SFL_ST_LRUN;
                    end
                end
            end
            default: begin
                state_next = SFL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= SFL_ST_IDLE;
            sp_reg    <= `SFL_SP_RESET;
            bp_reg    <= `SFL_BP_RESET;
            cw_reg    <= `SFL_CW_RESET;
            temp_reg  <= `SFL_ZERO16;
            wdata_reg <= `SFL_ZERO16;
            size_reg  <= `SFL_ZERO16;
            cnt_reg   <= `SFL_ZERO8;
            idx_reg   <= 3'h0;
            mode_reg  <= SFL_OP_PUSH_WORD;
            pend_reg  <= 1'b0;
            ready_reg <= 1'b0;
            exec_reg  <= 1'b0;
            adv_reg   <= 1'b0;
            done_reg  <= 1'b0;
            inh_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            sp_reg    <= sp_next;
            bp_reg    <= bp_next;
            cw_reg    <= cw_next;
            temp_reg  <= temp_next;
            wdata_reg <= wdata_next;
            size_reg  <= size_next;
            cnt_reg   <= cnt_next;
            idx_reg   <= idx_next;
            mode_reg  <= mode_next;
            pend_reg  <= pend_next;
            ready_reg <= (state_next == SFL_ST_IDLE);
            exec_reg  <= exec_next;
            adv_reg   <= adv_next;
            done_reg  <= done_next;
            inh_reg   <= state_next inside {SFL_ST_LRUN, SFL_ST_LWAIT};
        end
    end

    assign cmdReady           = ready_reg;
    assign regOut.stackTop    = sp_reg;
    assign regOut.frameBase   = bp_reg;
    assign regOut.loopCounter = cw_reg;
    assign execReq            = exec_reg;
    assign pcAdvance          = adv_reg;
    assign opDone             = done_reg;
    assign intInhibit         = inh_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_frame_saves_base;
        (state_reg == SFL_ST_FSAVE && accStart) |=> memReq && memOp.wdata == $past(bp_reg)
            && memOp.addr == 16'($past(sp_reg) - `SFL_WORD_BYTES);
    endproperty
    a_frame_saves_base: assert property (p_frame_saves_base) else $error("base not saved first");

    property p_copy_reads_base;
        (state_reg == SFL_ST_FREAD && accStart) |=> !memOp.we
            && memOp.addr == 16'($past(bp_reg) - `SFL_WORD_BYTES);
    endproperty
    a_copy_reads_base: assert property (p_copy_reads_base) else $error("copy address wrong");

    property p_depth_zero_skips;
        (state_reg == SFL_ST_FSAVE && accDone && cnt_reg == `SFL_ZERO8) |=> state_reg == SFL_ST_FDONE;
    endproperty
    a_depth_zero_skips: assert property (p_depth_zero_skips) else $error("depth zero not skipped");

    property p_frame_finish;
        (state_reg == SFL_ST_FDONE) |=> bp_reg == $past(temp_reg)
            && sp_reg == 16'($past(sp_reg) - $past(size_reg)) && opDone;
    endproperty
    a_frame_finish: assert property (p_frame_finish) else $error("frame finish wrong");

    property p_push_lowers_top;
        (state_reg == SFL_ST_PUSH && accDone) |=> sp_reg == 16'($past(sp_reg) - `SFL_WORD_BYTES);
    endproperty
    a_push_lowers_top: assert property (p_push_lowers_top) else $error("push step wrong");

    property p_imm8_extends;
        (state_reg == SFL_ST_IDLE && cmdValid && cmd.op == SFL_OP_PUSH_IMM8)
            |=> wdata_reg == {{8{$past(cmd.imm8[7])}}, $past(cmd.imm8)};
    endproperty
    a_imm8_extends: assert property (p_imm8_extends) else $error("imm8 not sign extended");

    property p_zero_count_skips;
        (state_reg == SFL_ST_IDLE && cmdValid && isLoop && cw_reg == `SFL_ZERO16)
            |=> pcAdvance && !execReq ##1 !execReq;
    endproperty
    a_zero_count_skips: assert property (p_zero_count_skips) else $error("zero count ran");

    property p_equal_exit;
        (state_reg == SFL_ST_LWAIT && execDone && mode_reg == SFL_OP_LOOP_WHILE_EQUAL
            && !execFlags.zero) |=> pcAdvance && state_reg == SFL_ST_IDLE;
    endproperty
    a_equal_exit: assert property (p_equal_exit) else $error("equal loop did not exit");

    property p_plain_repeats;
        (state_reg == SFL_ST_LWAIT && execDone && mode_reg == SFL_OP_LOOP_PLAIN
            && cw_reg > `SFL_ONE16) |=> !pcAdvance ##1 execReq;
    endproperty
    a_plain_repeats: assert property (p_plain_repeats) else $error("plain loop stopped");

    property p_carry_repeats;
        (state_reg == SFL_ST_LWAIT && execDone && mode_reg == SFL_OP_LOOP_WHILE_CARRY
            && execFlags.carry && cw_reg > `SFL_ONE16) |=> !pcAdvance ##1 execReq;
    endproperty
    a_carry_repeats: assert property (p_carry_repeats) else $error("carry loop stopped");

    property p_inhibit_held;
        (state_reg == SFL_ST_LWAIT) |-> intInhibit;
    endproperty
    a_inhibit_held: assert property (p_inhibit_held) else $error("interrupts not held off");

    c_frame_copy: cover property (state_reg == SFL_ST_FCOPY && accDone);
    c_regset_push: cover property (state_reg == SFL_ST_PALL && idx_reg == `SFL_REGSET_LAST && accDone);
    c_loop_repeat: cover property (execReq ##[1:20] execReq);
    c_carry_exit: cover property (mode_reg == SFL_OP_LOOP_WHILE_CARRY && pcAdvance);

endmodule

// ===== hw/sfl_params.svh
/*
 * Constants for the stack frame, stack push and loop prefix sequencer.
 * Assumes a 16-bit word, a downward-growing stack and byte addressing.
 */
`ifndef SFL_PARAMS_SVH
`define SFL_PARAMS_SVH

`define SFL_WORD_BYTES   16'h0002
`define SFL_REGSET_LAST  3'h7
`define SFL_REGSET_TEMP  3'h4
`define SFL_SP_RESET     16'h0000
`define SFL_BP_RESET     16'h0000
`define SFL_CW_RESET     16'h0000
`define SFL_ZERO16       16'h0000
`define SFL_ONE16        16'h0001
`define SFL_ZERO8        8'h00
`define SFL_ONE8         8'h01

`endif

// ===== hw/sfl_pkg.sv
/*
 * Types shared by the sequencer and its stack access port.
 * Assumes the includer has the constants header available.
 */
package sfl_pkg;

    typedef enum logic [2:0] {
        SFL_OP_PUSH_WORD        = 3'h0,
        SFL_OP_PUSH_IMM8        = 3'h1,
        SFL_OP_PUSH_REGSET      = 3'h2,
        SFL_OP_BUILD_FRAME      = 3'h3,
        SFL_OP_LOOP_PLAIN       = 3'h4,
        SFL_OP_LOOP_WHILE_EQUAL = 3'h5,
        SFL_OP_LOOP_WHILE_CARRY = 3'h6
    } sfl_op_t;

    typedef struct packed {
        sfl_op_t     op;
        logic [15:0] imm16;
        logic [7:0]  imm8;
        logic [15:0] operand;
    } sfl_cmd_t;

    typedef struct packed {
        logic [15:0] accumulatorWord;
        logic [15:0] dataPortRegister;
        logic [15:0] baseGeneralRegister;
        logic [15:0] sourcePointer;
        logic [15:0] destPointer;
    } sfl_gpr_t;

    typedef struct packed {
        logic [15:0] stackTop;
        logic [15:0] frameBase;
        logic [15:0] loopCounter;
    } sfl_ptrs_t;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } sfl_mem_req_t;

    typedef struct packed {
        logic zero;
        logic carry;
    } sfl_exec_res_t;

    typedef enum logic [9:0] {
        SFL_ST_IDLE  = 10'h001,
        SFL_ST_PUSH  = 10'h002,
        SFL_ST_FSAVE = 10'h004,
        SFL_ST_FREAD = 10'h008,
        SFL_ST_FCOPY = 10'h010,
        SFL_ST_FTEMP = 10'h020,
        SFL_ST_FDONE = 10'h040,
        SFL_ST_PALL  = 10'h080,
        SFL_ST_LRUN  = 10'h100,
        SFL_ST_LWAIT = 10'h200
    } sfl_state_t;

endpackage

// ===== hw/sfl_stack_port.sv
/*
 * Single-word stack memory access port with registered request outputs.
 * Assumes the memory answers each request with a one-cycle acknowledge.
 */
`timescale 1ns/10ps
`include "sfl_params.svh"

module sfl_stack_port
    import sfl_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         start,
    input  wire sfl_mem_req_t reqIn,
    output logic              done,
    output logic [15:0]       rdata,
    output logic              memReq,
    output sfl_mem_req_t      memOp,
    input  wire logic         memAck,
    input  wire logic [15:0]  memRdata
);

    logic         memReq_reg;
    logic         done_reg;
    logic [15:0]  rdata_reg;
    sfl_mem_req_t memOp_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // The request is held until acknowledged, so a slow memory simply stretches it.
    always_ff @(posedge mclk) begin
        if (rst) begin
            memReq_reg <= 1'b0;
            done_reg   <= 1'b0;
            rdata_reg  <= `SFL_ZERO16;
            memOp_reg  <= '0;
        end else begin
            done_reg <= memReq_reg && memAck;
            if (memReq_reg && memAck) begin
                memReq_reg <= 1'b0;
                rdata_reg  <= memRdata;
            end else if (start) begin
                memReq_reg <= 1'b1;
                memOp_reg  <= reqIn;
            end
        end
    end

    assign memReq = memReq_reg;
    assign memOp  = memOp_reg;
    assign done   = done_reg;
    assign rdata  = rdata_reg;

endmodule

// ===== tb/tb_sfl_exec.sv
/*
 * Self-checking bench for the frame, push and loop prefix sequencer.
 * Assumes the bench answers the stack memory and the governed instruction.
 */
`timescale 1ns/10ps

module tb_sfl_exec
    import sfl_pkg::*;
;
    logic          mclk = 1'b0;
    logic          rst = 1'b1;
    logic          cmdValid = 1'b0;
    sfl_cmd_t      cmd = '0;
    logic          cmdReady;
    sfl_gpr_t      gpr = {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555};
    logic          regLoad = 1'b0;
    sfl_ptrs_t     regIn = '0;
    sfl_ptrs_t     regOut;
    logic          memReq;
    sfl_mem_req_t  memOp;
    logic          memAck = 1'b0;
    logic [15:0]   memRdata = 16'h0000;
    logic          execReq;
    logic          execDone = 1'b0;
    sfl_exec_res_t execFlags = '0;
    logic          pcAdvance;
    logic          opDone;
    logic          intInhibit;
    logic          pcSeen;
    logic          mReqS;
    logic          mAckS;
    sfl_mem_req_t  mOpS;
    logic          eReqS;
    logic          mSlow = 1'b0;
    logic [15:0]   zeroBits;
    logic [15:0]   carryBits;
    logic [15:0]   mem [logic [15:0]];
    logic [15:0]   wa [$];
    logic [15:0]   wd [$];
    int            mDly = 0;
    int            runs = 0;
    int            err_count = 0;
    int            num_checks = 0;

    sfl_exec dut_u (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmd(cmd),
        .cmdReady(cmdReady), .gpr(gpr), .regLoad(regLoad), .regIn(regIn),
        .regOut(regOut), .memReq(memReq), .memOp(memOp), .memAck(memAck),
        .memRdata(memRdata), .execReq(execReq), .execDone(execDone),
        .execFlags(execFlags), .pcAdvance(pcAdvance), .opDone(opDone),
        .intInhibit(intInhibit));

    always #4 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////
    // Every other request is answered late so both memory paces are covered.
    always @(posedge mclk) begin
        mReqS = memReq;
        mAckS = memAck;
        mOpS = memOp;
        eReqS = execReq;
        #1;
        if (mReqS === 1'b1 && mAckS !== 1'b1 && mDly == 0) begin
            memAck = 1'b1;
            mSlow = !mSlow;
            mDly = mSlow ? 3 : 0;
            if (mOpS.we === 1'b1) begin
                wa.push_back(mOpS.addr);
                wd.push_back(mOpS.wdata);
            end else memRdata = mem[mOpS.addr];
        end else begin
            memAck = 1'b0;
            memRdata = ~memRdata;
            if (mReqS === 1'b1 && mDly > 0) mDly--;
        end
        // Flags idle at zero, so a design reading stale flags exits early.
        execDone = eReqS;
        execFlags = eReqS ? {zeroBits[runs], carryBits[runs]} : 2'b00;
        if (eReqS === 1'b1) begin
            chk(intInhibit, 1'b1);
            runs++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic await(ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1) begin
            tick;
            n++;
            if (n > 300) begin
                chk(16'h0000, 16'h0001);
                print_verdict;
            end
        end
    endtask

    task automatic load(input logic [15:0] sp, bp, cw);
        await(cmdReady);
        regLoad = 1'b1;
        regIn = '{sp, bp, cw};
        tick;
        regLoad = 1'b0;
        tick;
    endtask

    task automatic issue(input sfl_op_t op, input logic [15:0] i16,
                         input logic [7:0] i8, input logic [15:0] opnd);
        await(cmdReady);
        wa.delete();
        wd.delete();
        cmdValid = 1'b1;
        cmd = '{op, i16, i8, opnd};
        tick;
        cmdValid = 1'b0;
        await(opDone);
        pcSeen = pcAdvance;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic push_chk(input sfl_op_t op, input logic [7:0] i8,
                            input logic [15:0] opnd, input logic [15:0] exp);
        logic [15:0] sp0;
        sp0 = regOut.stackTop;
        issue(op, 16'h0000, i8, opnd);
        chk(wa.size(), 16'h0001);
        chk(wa[0], sp0 - 16'h0002);
        chk(wd[0], exp);
        chk(regOut.stackTop, sp0 - 16'h0002);
        chk(pcSeen, 1'b0);
        $display("push test done");
    endtask

    // Whole register set goes out in a fixed order; the spare op code must touch nothing.
    task automatic regset_chk;
        logic [15:0] ed [8];
        load(16'h0040, 16'h0050, 16'h0007);
        ed = '{gpr.accumulatorWord, 16'h0007, gpr.dataPortRegister, gpr.baseGeneralRegister,
               16'h0040, 16'h0050, gpr.sourcePointer, gpr.destPointer};
        issue(SFL_OP_PUSH_REGSET, 16'h0000, 8'h00, 16'h0000);
        chk(wa.size(), 16'h0008);
        for (int k = 0; k < 8; k++) begin
            chk(wa[k], 16'h0040 - 16'h0002 * (k[15:0] + 16'h0001));
            chk(wd[k], ed[k]);
        end
        chk(regOut.stackTop, 16'h0030);
        chk(pcSeen, 1'b0);
        issue(sfl_op_t'(3'h7), 16'h0000, 8'h00, 16'h0000);
        chk(wa.size(), 16'h0000);
        chk(regOut.stackTop, 16'h0030);
        chk(pcSeen, 1'b0);
        $display("regset test done");
    endtask

    task automatic frame_chk(input logic [15:0] sp, bp, i16, input logic [7:0] d);
        logic [15:0] ea [$];
        logic [15:0] ed [$];
        logic [15:0] s;
        logic [15:0] b;
        logic [15:0] t;
        load(sp, bp, 16'h0000);
        s = sp - 16'h0002;
        b = bp;
        t = s;
        ea.push_back(s);
        ed.push_back(bp);
        for (int k = 1; k < d; k++) begin
            b = b - 16'h0002;
            mem[b] = 16'hC000 + k[15:0];
            s = s - 16'h0002;
            ea.push_back(s);
            ed.push_back(16'hC000 + k[15:0]);
        end
        if (d != 8'h00) begin
            s = s - 16'h0002;
            ea.push_back(s);
            ed.push_back(t);
        end
        issue(SFL_OP_BUILD_FRAME, i16, d, 16'h0000);
        chk(wa.size(), ea.size());
        for (int k = 0; k < ea.size(); k++) begin
            chk(wa[k], ea[k]);
            chk(wd[k], ed[k]);
        end
        chk(regOut.frameBase, t);
        chk(regOut.stackTop, s - i16);
        $display("frame test done");
    endtask

    task automatic loop_chk(input sfl_op_t op, input logic [15:0] cnt, zb, cb,
                            input logic [15:0] expRuns);
        load(16'h0100, 16'h0200, cnt);
        runs = 0;
        zeroBits = zb;
        carryBits = cb;
        issue(op, 16'h0000, 8'h00, 16'h0000);
        chk(runs, expRuns);
        chk(pcSeen, 1'b1);
        chk(intInhibit, 1'b0);
        chk(regOut.loopCounter, cnt - expRuns);
        $display("loop test done");
    endtask

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        load(16'h0000, 16'h1234, 16'h0000);
        push_chk(SFL_OP_PUSH_WORD, 8'h00, 16'hBEEF, 16'hBEEF);
        push_chk(SFL_OP_PUSH_IMM8, 8'h80, 16'h0000, 16'hFF80);
        push_chk(SFL_OP_PUSH_IMM8, 8'h7F, 16'hFFFF, 16'h007F);
        regset_chk;
        frame_chk(16'h0058, 16'h0070, 16'h0006, 8'h03);
        frame_chk(16'h0058, 16'h0070, 16'h0006, 8'h01);
        frame_chk(16'h0058, 16'h0070, 16'h8001, 8'h00);
        frame_chk(16'h0004, 16'h0010, 16'h0010, 8'h01);
        loop_chk(SFL_OP_LOOP_PLAIN, 16'h0003, 16'h0000, 16'h0000, 16'h0003);
        loop_chk(SFL_OP_LOOP_PLAIN, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        loop_chk(SFL_OP_LOOP_WHILE_EQUAL, 16'h0005, 16'h001B, 16'h0000, 16'h0003);
        loop_chk(SFL_OP_LOOP_WHILE_EQUAL, 16'h0002, 16'hFFFF, 16'h0000, 16'h0002);
        loop_chk(SFL_OP_LOOP_WHILE_EQUAL, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000);
        loop_chk(SFL_OP_LOOP_WHILE_CARRY, 16'h0006, 16'h0000, 16'h0003, 16'h0003);
        loop_chk(SFL_OP_LOOP_WHILE_CARRY, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000);
        print_verdict;
    end

endmodule
